// ---- pkg/adc_queue_pkg.sv ----
// Shared constants, types and mode decoding for the queue scan controller.
package adc_queue_pkg;

    // Register byte offsets; the command table fills 64 words from its base.
    localparam int ADDR_W = 9;
    localparam logic [8:0] OFF_CTRL1 = 9'h000;
    localparam logic [8:0] OFF_CTRL2 = 9'h004;
    localparam logic [8:0] OFF_STATUS = 9'h008;
    localparam logic [8:0] OFF_TABLE = 9'h100;

    // Control register fields.
    localparam int MODE_LSB = 0;
    localparam int SSE_BIT = 4;
    localparam int PTR_LSB = 8;

    // Status register fields; flag bits clear by writing one.
    localparam int ST_DONE1 = 0;
    localparam int ST_PAUSE1 = 1;
    localparam int ST_OVR1 = 2;
    localparam int ST_DONE2 = 3;
    localparam int ST_PAUSE2 = 4;
    localparam int ST_OVR2 = 5;
    localparam int ST_QSTATE_LSB = 8;
    localparam int ST_BOTH_OFF = 12;

    // Command table layout.
    localparam int TABLE_DEPTH = 64;
    localparam logic [5:0] END_OF_QUEUE_CODE = 6'h3F;

    // Reset values.
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [6:0] START2_RESET = 7'h7F;

    // Interval timer period in converter clock cycles.
    localparam logic [16:0] TIMER_CYCLES = 17'h00080;

    // Queue mode field encodings; codes not listed are reserved.
    localparam logic [3:0] M_DISABLED = 4'h0;
    localparam logic [3:0] M_SW_SINGLE = 4'h1;
    localparam logic [3:0] M_RISE_SINGLE = 4'h2;
    localparam logic [3:0] M_FALL_SINGLE = 4'h3;
    localparam logic [3:0] M_GATE_SINGLE = 4'h4;
    localparam logic [3:0] M_TIMER_SINGLE = 4'h5;
    localparam logic [3:0] M_SW_CONT = 4'h9;
    localparam logic [3:0] M_RISE_CONT = 4'hA;
    localparam logic [3:0] M_FALL_CONT = 4'hB;
    localparam logic [3:0] M_GATE_CONT = 4'hC;
    localparam logic [3:0] M_TIMER_CONT = 4'hD;

    // Queue status codes, two bits per queue.
    localparam logic [1:0] QS_IDLE = 2'h0;
    localparam logic [1:0] QS_ACTIVE = 2'h1;
    localparam logic [1:0] QS_PAUSED = 2'h2;
    localparam logic [1:0] QS_PENDING = 2'h3;

    typedef struct packed {
        logic pause;
        logic [5:0] chan;
    } ccw_t;

    typedef struct packed {
        logic start;
        logic abort;
        logic [5:0] chan;
    } conv_req_t;

    function automatic logic mode_base(input logic [3:0] m, output logic [2:0] b);
        b = m[2:0];
        mode_base = (m[2:0] >= 3'h1) && (m[2:0] <= 3'h5) && (m[3:3] == 1'b0 || m[2:0] != 3'h0);
    endfunction

    function automatic logic mode_live(input logic [3:0] m);
        mode_live = (m >= M_SW_SINGLE && m <= M_TIMER_SINGLE) ||
                    (m >= M_SW_CONT && m <= M_TIMER_CONT);
    endfunction

    function automatic logic mode_single(input logic [3:0] m);
        mode_single = (m >= M_SW_SINGLE && m <= M_TIMER_SINGLE);
    endfunction

    function automatic logic [2:0] mode_kind(input logic [3:0] m);
        mode_kind = mode_live(m) ? m[2:0] : 3'h0;
    endfunction

endpackage

// ---- verif/conv_core_model.sv ----
// Behavioural conversion core that answers each start that is not aborted after a set delay.
`timescale 1ns/1ps
module conv_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Requests from the sequencer
    input wire adc_queue_pkg::conv_req_t conv_req,
    input wire logic [7:0] delay,
    // Answer and bookkeeping
    output logic conv_done,
    output int starts,
    output int aborts,
    output logic [5:0] last_chan
);
    logic busy_r;
    logic [7:0] cnt_r;

    // An aborted conversion owes no done pulse, so a stale answer cannot leak out.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
            conv_done <= 1'b0;
            starts <= 0;
            aborts <= 0;
            last_chan <= 6'h00;
        end
        else
        begin
            conv_done <= 1'b0;
            if (conv_req.abort)
            begin
                busy_r <= 1'b0;
                aborts <= aborts + 1;
            end
            else if (conv_req.start)
            begin
                busy_r <= 1'b1;
                cnt_r <= delay;
                starts <= starts + 1;
                last_chan <= conv_req.chan;
            end
            else if (busy_r && cnt_r == 8'h00)
            begin
                conv_done <= 1'b1;
                busy_r <= 1'b0;
            end
            else if (busy_r)
                cnt_r <= cnt_r - 8'h01;
        end
    end
endmodule

// ---- verif/tb_adc_queue_scan_control.sv ----
// Self-checking bench for the queue scan controller.
`timescale 1ns/1ps
module tb_adc_queue_scan_control;
    localparam logic [8:0] C1 = adc_queue_pkg::OFF_CTRL1;
    localparam logic [8:0] C2 = adc_queue_pkg::OFF_CTRL2;
    localparam logic [8:0] ST = adc_queue_pkg::OFF_STATUS;
    localparam logic [31:0] D1 = 32'h1 << adc_queue_pkg::ST_DONE1;
    localparam logic [31:0] P1 = 32'h1 << adc_queue_pkg::ST_PAUSE1;
    localparam logic [31:0] O1 = 32'h1 << adc_queue_pkg::ST_OVR1;
    localparam logic [31:0] D2 = 32'h1 << adc_queue_pkg::ST_DONE2;
    localparam logic [31:0] OFF = 32'h1 << adc_queue_pkg::ST_BOTH_OFF;
    localparam logic [3:0] IDLE_MODES [6] = '{4'h0, 4'h6, 4'h7, 4'h8, 4'hE, 4'hF};
    logic clk;
    logic rst;
    logic [8:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic trig1_pin;
    logic trig2_pin;
    adc_queue_pkg::conv_req_t conv_req;
    logic conv_done;
    logic [3:0] queue_state;
    logic both_disabled;
    logic [7:0] delay;
    logic [5:0] last_chan;
    int starts;
    int aborts;
    int base;
    int base_ab;
    int errors;
    int comparisons;

    adc_queue_scan_control adc_queue_scan_control_i (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trig1_pin(trig1_pin),
        .trig2_pin(trig2_pin), .conv_req(conv_req), .conv_done(conv_done),
        .queue_state(queue_state), .both_disabled(both_disabled));
    conv_core_model conv_core_model_i (.clk(clk), .rst(rst), .conv_req(conv_req),
        .delay(delay), .conv_done(conv_done), .starts(starts), .aborts(aborts),
        .last_chan(last_chan));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic chk_reg(input logic [8:0] a, input logic [31:0] exp, input string msg);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, msg);
    endtask

    task automatic tbl(input int n, input logic [31:0] w);
        wr_reg(adc_queue_pkg::OFF_TABLE + 9'(4 * n), w);
    endtask

    task automatic pulse1();
        @(posedge clk);
        trig1_pin <= 1'b1;
        @(posedge clk);
        trig1_pin <= 1'b0;
    endtask

    // Waits for both queues to fall idle, with a bound so a stuck queue cannot hang.
    task automatic run_out();
        repeat (4) @(posedge clk);
        for (int i = 0; i < 400 && queue_state !== 4'h0; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
    endtask

    task automatic mark();
        base = starts;
        base_ab = aborts;
    endtask

    task automatic chk_conv(input int n, input string msg);
        chk(32'(starts - base), 32'(n), msg);
    endtask

    task automatic end_test(input string name);
        wr_reg(ST, 32'h3F);
        $display("test %s finished", name);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial
    begin
        {addr, wdata, wr, rd, trig1_pin, trig2_pin} = '0;
        errors = 0;
        comparisons = 0;
        delay = 8'h02;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        chk_reg(ST, OFF, "reset status");
        chk_reg(C2, 32'h7F00, "reset ctrl2");
        tbl(0, 32'h3F);
        mark();
        wr_reg(C1, 32'h11);
        run_out();
        chk_conv(0, "end code first");
        chk_reg(ST, D1, "end code status");
        chk_reg(C1, 32'h01, "enable reads zero");
        end_test("end_code_first");
        tbl(0, 32'h41);
        tbl(1, 32'h42);
        wr_reg(C2, 32'h0200);
        mark();
        wr_reg(C1, 32'h11);
        run_out();
        chk_conv(2, "pause then pointer end");
        chk(32'(last_chan), 32'h2, "last channel");
        chk_reg(ST, D1 | P1, "pause and done");
        end_test("pause_then_end");
        tbl(0, 32'h7F);
        mark();
        wr_reg(C1, 32'h11);
        run_out();
        chk_conv(0, "pause with end");
        chk_reg(ST, D1, "end wins");
        end_test("pause_with_end");
        wr_reg(C2, 32'h0000);
        for (int i = 0; i < 2; i++)
        begin
            tbl(0, i != 0 ? 32'h3F : 32'h01);
            mark();
            wr_reg(C1, 32'h11);
            run_out();
            chk_conv(0, "pointer zero");
            chk_reg(ST, D1, "pointer zero status");
            wr_reg(ST, 32'h3F);
        end
        $display("test pointer_zero finished");
        tbl(63, 32'h05);
        mark();
        wr_reg(C2, 32'h3F11);
        run_out();
        chk_conv(1, "pointer last entry");
        chk(32'(last_chan), 32'h5, "last entry channel");
        chk_reg(ST, D2, "queue 2 done");
        end_test("pointer_last");
        mark();
        wr_reg(C2, 32'h4011);
        run_out();
        chk_conv(0, "pointer beyond table");
        chk_reg(ST, D2, "beyond table status");
        end_test("pointer_beyond");
        wr_reg(C2, 32'h7F00);
        mark();
        foreach (IDLE_MODES[i])
        begin
            wr_reg(C1, {27'h0, 1'b1, IDLE_MODES[i]});
            pulse1();
            repeat (8) @(posedge clk);
            chk_conv(0, "idle mode started");
            chk(32'(both_disabled), 32'h1, "both disabled");
        end
        end_test("idle_modes");
        tbl(0, 32'h01);
        tbl(1, 32'h3F);
        delay = 8'h28;
        wr_reg(C1, 32'h02);
        pulse1();
        repeat (8) @(posedge clk);
        chk_conv(0, "no enable no start");
        wr_reg(C1, 32'h12);
        pulse1();
        repeat (8) @(posedge clk);
        chk(32'(queue_state[1:0]), 32'(adc_queue_pkg::QS_ACTIVE), "active");
        pulse1();
        wr_reg(C1, 32'h02);
        run_out();
        chk_conv(1, "one edge scan");
        chk(32'(aborts - base_ab), 32'h0, "same mode write");
        chk(32'(last_chan), 32'h1, "first word");
        chk_reg(ST, D1 | O1, "overrun");
        pulse1();
        repeat (10) @(posedge clk);
        chk_conv(1, "enable cleared");
        end_test("edge_single");
        wr_reg(C1, 32'h12);
        pulse1();
        repeat (8) @(posedge clk);
        wr_reg(C1, 32'h00);
        repeat (4) @(posedge clk);
        chk(32'(aborts - base_ab), 32'h1, "mode change abort");
        chk(32'(queue_state), 32'h0, "idle after abort");
        end_test("mode_change");
        delay = 8'h02;
        mark();
        wr_reg(C1, 32'h15);
        repeat (100) @(posedge clk);
        chk_conv(0, "timer too early");
        repeat (60) @(posedge clk);
        chk_conv(1, "timer expiry");
        run_out();
        chk_reg(ST, D1, "timer done");
        end_test("timer_single");
        tally_and_finish();
    end
endmodule

// ---- verilog/adc_queue_scan_control.sv ----
// Queue sequencer for two command queues sharing one conversion command table.
`timescale 1ns/1ps
module adc_queue_scan_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [8:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // External trigger pins
    input wire logic trig1_pin,
    input wire logic trig2_pin,
    // Conversion core
    output adc_queue_pkg::conv_req_t conv_req,
    input wire logic conv_done,
    // Status
    output logic [3:0] queue_state,
    output logic both_disabled
);

    typedef enum logic [1:0] {S_IDLE, S_READ, S_CONV} seq_t;

    seq_t state_r;
    adc_queue_pkg::ccw_t table_r [0:63];
    logic [1:0][3:0] mode_r;
    logic [1:0] sse_r;
    logic [6:0] start2_r;
    logic [1:0] done_r;
    logic [1:0] pause_f_r;
    logic [1:0] ovr_r;
    logic [1:0] pend_r;
    logic [1:0] paused_r;
    logic [1:0][6:0] resume_r;
    logic cur_q_r;
    logic [6:0] ptr_r;
    logic ccw_pause_r;
    logic [1:0] pin_prev_r;
    logic [16:0] timer_r;
    logic timer_tick;
    logic [31:0] rdata_r;
    adc_queue_pkg::conv_req_t conv_r;
    logic [3:0] qstate_r;
    logic both_off_r;

    logic [1:0] pin;
    logic [1:0] ctrl_wr;
    logic [1:0] mode_chg;
    logic [1:0] trig;
    logic [1:0] busy;
    logic [1:0] ovr_mode;
    logic [1:0] start_q;
    logic [1:0] finish_q;
    logic [1:0] hold_q;
    logic [1:0] pause_q;
    logic kill;
    logic preempt;
    logic read_eoq;
    logic nxt_eoq;
    logic [6:0] nxt_ptr;
    logic status_wr;
    adc_queue_pkg::ccw_t cur_ccw;
    adc_queue_pkg::ccw_t nxt_ccw;

    assign pin = {trig2_pin, trig1_pin};
    assign status_wr = wr && addr == adc_queue_pkg::OFF_STATUS;
    assign cur_ccw = table_r[ptr_r[5:0]];
    assign nxt_ptr = ptr_r + 7'h01;
    assign nxt_ccw = table_r[nxt_ptr[5:0]];

    // End of queue: past the table, end code, or queue 2 start during queue 1.
    assign read_eoq = ptr_r[6] || cur_ccw.chan == adc_queue_pkg::END_OF_QUEUE_CODE ||
                      (!cur_q_r && ptr_r == start2_r);
    assign nxt_eoq = nxt_ptr[6] || nxt_ccw.chan == adc_queue_pkg::END_OF_QUEUE_CODE ||
                     (!cur_q_r && nxt_ptr == start2_r);

    // Per-queue trigger decoding.
    genvar q;
    generate
        for (q = 0; q < 2; q++)
        begin : g_queue
            logic raw;
            logic en;
            logic [2:0] kind;
            logic sw_write;
            logic kick_r;
            assign ctrl_wr[q] = wr && addr == (q == 0 ? adc_queue_pkg::OFF_CTRL1
                                                      : adc_queue_pkg::OFF_CTRL2);
            assign mode_chg[q] = ctrl_wr[q] && wdata[adc_queue_pkg::MODE_LSB +: 4] != mode_r[q];
            assign kind = adc_queue_pkg::mode_kind(mode_r[q]);
            assign sw_write = ctrl_wr[q] && !mode_chg[q] && wdata[adc_queue_pkg::SSE_BIT] &&
                              !sse_r[q];
            // A write that selects software single mode and sets the enable kicks one cycle
            // later, because the mode change itself clears any pending trigger.
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    kick_r <= 1'b0;
                else
                    kick_r <= mode_chg[q] && wdata[adc_queue_pkg::SSE_BIT] &&
                              wdata[adc_queue_pkg::MODE_LSB +: 4] == adc_queue_pkg::M_SW_SINGLE;
            end
            always_comb
            begin
                raw = 1'b0;
                unique case (kind)
                    3'h1: raw = mode_r[q] == adc_queue_pkg::M_SW_SINGLE ? (sw_write || kick_r) : 1'b1;
                    3'h2: raw = pin[q] && !pin_prev_r[q];
                    3'h3: raw = !pin[q] && pin_prev_r[q];
                    3'h4: raw = pin[q];
                    3'h5: raw = timer_tick;
                    default: raw = 1'b0;
                endcase
            end
            // Single-scan modes need the enable; a software write counts as setting it.
            assign en = adc_queue_pkg::mode_live(mode_r[q]) &&
                        (!adc_queue_pkg::mode_single(mode_r[q]) || sse_r[q] || sw_write);
            assign trig[q] = en && raw && !mode_chg[q];
            assign ovr_mode[q] = kind == 3'h2 || kind == 3'h3 || kind == 3'h5;
            assign busy[q] = pend_r[q] || (state_r != S_IDLE && cur_q_r == q);
        end
    endgenerate

    // Sequencer events.
    always_comb
    begin
        kill = state_r != S_IDLE && mode_chg[cur_q_r];
        preempt = state_r == S_CONV && cur_q_r && pend_r[0];
        start_q = 2'h0;
        finish_q = 2'h0;
        hold_q = 2'h0;
        pause_q = 2'h0;
        if (state_r == S_IDLE)
        begin
            if (pend_r[0])
                start_q = 2'h1;
            else if (pend_r[1])
                start_q = 2'h2;
        end
        else if (!kill && !preempt)
        begin
            if (state_r == S_READ && read_eoq)
                finish_q[cur_q_r] = 1'b1;
            if (state_r == S_CONV && conv_done)
            begin
                pause_q[cur_q_r] = ccw_pause_r;
                if (nxt_eoq)
                    finish_q[cur_q_r] = 1'b1;
                else if (ccw_pause_r && mode_r[cur_q_r] != adc_queue_pkg::M_SW_SINGLE)
                    hold_q[cur_q_r] = 1'b1;
            end
        end
    end

    // Sequencer state.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= S_IDLE;
            cur_q_r <= 1'b0;
            ptr_r <= 7'h00;
            ccw_pause_r <= 1'b0;
        end
        else if (kill || preempt)
            state_r <= S_IDLE;
        else
        begin
            unique case (state_r)
                S_IDLE:
                    if (start_q != 2'h0)
                    begin
                        state_r <= S_READ;
                        cur_q_r <= start_q[1];
                        if (paused_r[start_q[1]])
                            ptr_r <= resume_r[start_q[1]];
                        else
                            ptr_r <= start_q[1] ? start2_r : 7'h00;
                    end
                S_READ:
                    if (read_eoq)
                        state_r <= S_IDLE;
                    else
                    begin
                        state_r <= S_CONV;
                        ccw_pause_r <= cur_ccw.pause;
                    end
                S_CONV:
                    if (conv_done)
                    begin
                        if (nxt_eoq || hold_q != 2'h0)
                            state_r <= S_IDLE;
                        else
                            state_r <= S_READ;
                        ptr_r <= nxt_ptr;
                    end
            endcase
        end
    end

    // Requests to the conversion core.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            conv_r <= '0;
        else
        begin
            conv_r.start <= state_r == S_READ && !read_eoq && !kill;
            conv_r.abort <= state_r == S_CONV && (kill || preempt);
            conv_r.chan <= cur_ccw.chan;
        end
    end

    // Pending triggers, pauses and resume points.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_r <= 2'h0;
            paused_r <= 2'h0;
            resume_r <= '0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (mode_chg[i])
                begin
                    pend_r[i] <= 1'b0;
                    paused_r[i] <= 1'b0;
                end
                else if (trig[i] && !busy[i])
                    pend_r[i] <= 1'b1;
                else if (start_q[i])
                    pend_r[i] <= 1'b0;
                if (start_q[i] || finish_q[i])
                    paused_r[i] <= 1'b0;
                if (hold_q[i])
                begin
                    paused_r[i] <= 1'b1;
                    resume_r[i] <= nxt_ptr;
                end
            end
            // A suspended queue 2 restarts from its first word after queue 1.
            if (preempt)
            begin
                pend_r[1] <= 1'b1;
                paused_r[1] <= 1'b0;
            end
        end
    end

    // Control registers and single-scan enables.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_r <= {adc_queue_pkg::MODE_RESET, adc_queue_pkg::MODE_RESET};
            sse_r <= 2'h0;
            start2_r <= adc_queue_pkg::START2_RESET;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (ctrl_wr[i])
                    mode_r[i] <= wdata[adc_queue_pkg::MODE_LSB +: 4];
                if (mode_chg[i])
                    sse_r[i] <= wdata[adc_queue_pkg::SSE_BIT];
                else if (finish_q[i])
                    sse_r[i] <= 1'b0;
                else if (ctrl_wr[i] && wdata[adc_queue_pkg::SSE_BIT])
                    sse_r[i] <= 1'b1;
            end
            if (ctrl_wr[1])
                start2_r <= wdata[adc_queue_pkg::PTR_LSB +: 7];
        end
    end

    // Command table storage.
    always_ff @(posedge clk)
    begin
        if (wr && addr[8])
            table_r[addr[7:2]] <= adc_queue_pkg::ccw_t'(wdata[6:0]);
    end

    // Sticky flags; a hardware set in the clearing cycle wins.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            done_r <= 2'h0;
            pause_f_r <= 2'h0;
            ovr_r <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                done_r[i] <= finish_q[i] ||
                    (done_r[i] && !(status_wr && wdata[3 * i + adc_queue_pkg::ST_DONE1]));
                pause_f_r[i] <= pause_q[i] ||
                    (pause_f_r[i] && !(status_wr && wdata[3 * i + adc_queue_pkg::ST_PAUSE1]));
                ovr_r[i] <= (trig[i] && busy[i] && ovr_mode[i]) ||
                    (ovr_r[i] && !(status_wr && wdata[3 * i + adc_queue_pkg::ST_OVR1]));
            end
        end
    end

    // Interval timer; it restarts whenever no queue waits on it.
    assign timer_tick = timer_r == adc_queue_pkg::TIMER_CYCLES - 17'h00001;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            timer_r <= 17'h00000;
            pin_prev_r <= 2'h0;
        end
        else
        begin
            pin_prev_r <= pin;
            if ((mode_r[0] == adc_queue_pkg::M_TIMER_SINGLE && sse_r[0]) ||
                (mode_r[1] == adc_queue_pkg::M_TIMER_SINGLE && sse_r[1]) ||
                mode_r[0] == adc_queue_pkg::M_TIMER_CONT || mode_r[1] == adc_queue_pkg::M_TIMER_CONT)
                timer_r <= timer_tick ? 17'h00000 : timer_r + 17'h00001;
            else
                timer_r <= 17'h00000;
        end
    end

    // Queue status field and register read port.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            qstate_r <= 4'h0;
            both_off_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (busy[i] && !pend_r[i])
                    qstate_r[2 * i +: 2] <= adc_queue_pkg::QS_ACTIVE;
                else if (pend_r[i])
                    qstate_r[2 * i +: 2] <= adc_queue_pkg::QS_PENDING;
                else if (paused_r[i])
                    qstate_r[2 * i +: 2] <= adc_queue_pkg::QS_PAUSED;
                else
                    qstate_r[2 * i +: 2] <= adc_queue_pkg::QS_IDLE;
            end
            // The slave answers every access in one cycle, so no wait state ever arises.
            both_off_r <= !adc_queue_pkg::mode_live(mode_r[0]) &&
                          !adc_queue_pkg::mode_live(mode_r[1]);
            rdata_r <= 32'h00000000;
            if (rd)
            begin
                if (addr[8])
                    rdata_r <= {25'h0000000, table_r[addr[7:2]]};
                else if (addr == adc_queue_pkg::OFF_CTRL1)
                    rdata_r <= {28'h0000000, mode_r[0]};
                else if (addr == adc_queue_pkg::OFF_CTRL2)
                    rdata_r <= {17'h00000, start2_r, 4'h0, mode_r[1]};
                else if (addr == adc_queue_pkg::OFF_STATUS)
                    rdata_r <= {19'h00000, both_off_r, qstate_r, 2'h0, ovr_r[1], pause_f_r[1],
                                done_r[1], ovr_r[0], pause_f_r[0], done_r[0]};
            end
        end
    end

    assign rdata = rdata_r;
    assign conv_req = conv_r;
    assign queue_state = qstate_r;
    assign both_disabled = both_off_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence read_end_s;
        state_r == S_READ && read_eoq && !kill && !preempt;
    endsequence

    chk_eoq_no_conversion: assert property (read_end_s |=> !conv_r.start && done_r[$past(cur_q_r)])
        else $error("end of queue read started a conversion");
    chk_beyond_table_end: assert property (state_r == S_READ && ptr_r[6] |-> read_eoq)
        else $error("pointer beyond table did not end the queue");
    chk_start2_ends_q1: assert property (state_r == S_READ && !cur_q_r && ptr_r == start2_r |=> state_r == S_IDLE)
        else $error("queue 1 ran past queue 2 start");
    chk_disabled_no_pend: assert property (!adc_queue_pkg::mode_live(mode_r[0]) && !pend_r[0] |=> !pend_r[0])
        else $error("disabled queue accepted a trigger");
    chk_enable_reads_zero: assert property (rd && addr == adc_queue_pkg::OFF_CTRL1 |=> rdata[adc_queue_pkg::SSE_BIT] == 1'b0)
        else $error("single scan enable read back as one");
    chk_enable_clear_done: assert property (finish_q[0] && !mode_chg[0] |=> !sse_r[0] && done_r[0])
        else $error("enable not cleared at completion");
    chk_sw_write_starts: assert property (mode_r[0] == adc_queue_pkg::M_SW_SINGLE && ctrl_wr[0] && !mode_chg[0] && wdata[adc_queue_pkg::SSE_BIT] && !sse_r[0] && !busy[0] && state_r == S_IDLE |=> pend_r[0] ##1 state_r == S_READ)
        else $error("software enable write did not start queue 1");
    chk_overrun_edge: assert property (trig[1] && busy[1] && ovr_mode[1] |=> ovr_r[1])
        else $error("trigger overrun not recorded");
    chk_pause_then_end: assert property (state_r == S_CONV && conv_done && ccw_pause_r && nxt_eoq && !kill && !preempt |=> pause_f_r[$past(cur_q_r)] && state_r == S_IDLE ##1 qstate_r[2 * $past(cur_q_r, 2) +: 2] != adc_queue_pkg::QS_PAUSED)
        else $error("pause before end left the queue paused");
    chk_mode_change_abort: assert property (state_r == S_CONV && kill |=> conv_r.abort && state_r == S_IDLE)
        else $error("mode change did not abort the conversion");

endmodule
